/* File: logic/pie_pkg.sv */
// Constants for the prioritized interrupt and event transfer controller
package pie_pkg;
  localparam int NODES = 16;
  localparam int CHANS = 8;
  localparam int EXT_INS = 4;
  localparam int SHARED = 12;
  localparam int PRIO_W = 4;
  localparam int LEVELS = 16;
  localparam int NODE_W = 4;
  localparam int CH_W = 3;
  localparam int PTR_W = 16;
  localparam int CNT_W = 8;
  localparam int VEC_W = 16;
  localparam int TRAP_W = 8;
  localparam int ADDR_W = 12;
  // Trap number of node 0; vector is four times the trap number
  localparam logic [TRAP_W-1:0] FIRST_TRAP = 8'h10;
  localparam int VEC_SHIFT = 2;
  // Node control word fields
  localparam int NC_PRIO_LSB = 0;
  localparam int NC_EN_BIT = 6;
  localparam int NC_REQ_BIT = 7;
  localparam int NC_ROUTE_BIT = 8;
  localparam int NC_CH_LSB = 9;
  // Channel configuration fields
  localparam int CFG_W = 4;
  localparam int CFG_WORD = 0;
  localparam int CFG_INC_SRC = 1;
  localparam int CFG_INC_DST = 2;
  localparam int CFG_CONT = 3;
  // Edge select bits per fast input
  localparam int EDGE_RISE = 0;
  localparam int EDGE_FALL = 1;
  // Register map
  localparam int WORD_LSB = 2;
  localparam int NODE_IDX_MSB = 5;
  localparam int CH_IDX_LSB = 4;
  localparam int CH_IDX_MSB = 6;
  localparam logic [ADDR_W-1:0] NODE_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] NODE_SPAN = 12'h040;
  localparam logic [ADDR_W-1:0] CHAN_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] CHAN_SPAN = 12'h080;
  localparam logic [3:0] CH_SRC = 4'h0;
  localparam logic [3:0] CH_DST = 4'h4;
  localparam logic [3:0] CH_CNT = 4'h8;
  localparam logic [3:0] CH_CFG = 4'hC;
  localparam logic [ADDR_W-1:0] EDGE_OFF = 12'h200;
  localparam logic [ADDR_W-1:0] STAT_OFF = 12'h204;
  localparam logic [ADDR_W-1:0] MASK_OFF = 12'h208;
  localparam logic [ADDR_W-1:0] ISR_OFF = 12'h20C;
  localparam logic [PTR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [PTR_W-1:0] STEP_WORD = 16'h0002;
endpackage

/* File: logic/pie_ctrl.sv */
// Prioritized interrupt controller with eight event transfer channels
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Per-node request, enable and priority; both needed
// - Sixteen priority levels for arbitration
// - Preempt only for strictly higher level
// - Each node has its own vector
// - Node routed to vector or transfer channel
// - Transfer steals exactly one CPU cycle
// - Move byte or word, increment pointers
// - Count decrements unless continuous mode
// - Count zero raises node's vectored interrupt
// - Eight independent transfer channels
// - Fast inputs: rising, falling or both edges
// - Software trap jumps to trap vector
// - Software may set request flag
// - Vector is four times trap number
// - Nodes 0-11 accept a second source
// - Request reaches CPU within few clocks
module pie_ctrl
  import pie_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NODES-1:0] node_hw_req,
  input wire logic [SHARED-1:0] node_alt_req,
  input wire logic [EXT_INS-1:0] fast_ext_pin,
  output logic irq_valid,
  output logic [VEC_W-1:0] irq_vector,
  output logic [PRIO_W-1:0] irq_level,
  input wire logic cpu_ack,
  input wire logic cpu_ret,
  input wire logic sw_trap,
  input wire logic [TRAP_W-1:0] sw_trap_num,
  output logic trap_valid,
  output logic [VEC_W-1:0] trap_vector,
  output logic move_valid,
  output logic [PTR_W-1:0] move_src,
  output logic [PTR_W-1:0] move_dst,
  output logic move_word,
  output logic cpu_stall,
  output logic irq_out
);

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] span);
    in_range = (a >= base) && (a < base + span);
  endfunction

  function automatic logic [PRIO_W-1:0] top_level(
    input logic [LEVELS-1:0] m);
    top_level = '0;
    for (int k = 0; k < LEVELS; k++)
    begin
      if (m[k])
        top_level = PRIO_W'(k);
    end
  endfunction

  // Node and channel state
  logic [PRIO_W-1:0] prio_reg [NODES];
  logic [CH_W-1:0] chsel_reg [NODES];
  logic [NODES-1:0] en_reg;
  logic [NODES-1:0] req_reg;
  logic [NODES-1:0] route_reg;
  logic [PTR_W-1:0] src_reg [CHANS];
  logic [PTR_W-1:0] dst_reg [CHANS];
  logic [CNT_W-1:0] cnt_reg [CHANS];
  logic [CFG_W-1:0] cfg_reg [CHANS];
  logic [2*EXT_INS-1:0] edge_reg;
  logic [CHANS-1:0] stat_reg;
  logic [CHANS-1:0] mask_reg;
  logic [LEVELS-1:0] isr_reg;
  logic [LEVELS-1:0] isr_next;
  logic [EXT_INS-1:0] ext_s1_reg;
  logic [EXT_INS-1:0] ext_s2_reg;
  logic [EXT_INS-1:0] ext_s3_reg;
  logic [NODE_W-1:0] irq_node_reg;
  logic irq_valid_reg;
  logic [VEC_W-1:0] irq_vector_reg;
  logic [PRIO_W-1:0] irq_level_reg;
  logic trap_valid_reg;
  logic [VEC_W-1:0] trap_vector_reg;
  logic move_valid_reg;
  logic [PTR_W-1:0] move_src_reg;
  logic [PTR_W-1:0] move_dst_reg;
  logic move_word_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // Bus decode
  wire logic setup_ph = psel & ~penable;
  wire logic wr_acc = psel & penable & pwrite;
  wire logic node_hit = in_range(paddr, NODE_BASE, NODE_SPAN);
  wire logic chan_hit = in_range(paddr, CHAN_BASE, CHAN_SPAN);
  wire logic edge_hit = (paddr == EDGE_OFF);
  wire logic stat_hit = (paddr == STAT_OFF);
  wire logic mask_hit = (paddr == MASK_OFF);
  wire logic isr_hit = (paddr == ISR_OFF);
  wire logic [ADDR_W-1:0] node_off = paddr - NODE_BASE;
  wire logic [ADDR_W-1:0] chan_off = paddr - CHAN_BASE;
  wire logic [NODE_W-1:0] node_idx = node_off[NODE_IDX_MSB:WORD_LSB];
  wire logic [CH_W-1:0] ch_idx = chan_off[CH_IDX_MSB:CH_IDX_LSB];
  wire logic [3:0] ch_fld = chan_off[CH_IDX_LSB-1:0];
  wire logic any_hit = node_hit | chan_hit | edge_hit | stat_hit |
    mask_hit | isr_hit;

  // Fast external input edges
  wire logic [EXT_INS-1:0] ext_rise = ext_s2_reg & ~ext_s3_reg;
  wire logic [EXT_INS-1:0] ext_fall = ~ext_s2_reg & ext_s3_reg;
  logic [EXT_INS-1:0] ext_evt;
  logic [SHARED-1:0] alt_src;

  always_comb
  begin
    for (int e = 0; e < EXT_INS; e++)
    begin
      ext_evt[e] = (ext_rise[e] & edge_reg[2*e+EDGE_RISE]) |
        (ext_fall[e] & edge_reg[2*e+EDGE_FALL]);
    end
  end

  // External events share nodes 0-3 and 8-11 with their second sources
  always_comb
  begin
    alt_src = node_alt_req;
    alt_src[EXT_INS-1:0] = node_alt_req[EXT_INS-1:0] | ext_evt;
    alt_src[2*EXT_INS+EXT_INS-1:2*EXT_INS] =
      node_alt_req[2*EXT_INS+EXT_INS-1:2*EXT_INS] | ext_evt;
  end

  // Arbitration
  logic best_valid;
  logic [NODE_W-1:0] best_idx;
  logic [PRIO_W-1:0] best_prio;

  always_comb
  begin
    best_valid = 1'b0;
    best_idx = '0;
    best_prio = '0;
    for (int i = NODES - 1; i >= 0; i--)
    begin
      if (req_reg[i] && en_reg[i] &&
        (!best_valid || prio_reg[i] >= best_prio))
      begin
        best_valid = 1'b1;
        best_idx = NODE_W'(i);
        best_prio = prio_reg[i];
      end
    end
  end

  wire logic busy = |isr_reg;
  wire logic [PRIO_W-1:0] cur_level = top_level(isr_reg);
  wire logic win_ok = best_valid &&
    (!busy || best_prio > cur_level);
  wire logic [CH_W-1:0] win_ch = chsel_reg[best_idx];
  wire logic [CFG_W-1:0] win_cfg = cfg_reg[win_ch];
  wire logic [CNT_W-1:0] win_cnt = cnt_reg[win_ch];
  wire logic win_cont = win_cfg[CFG_CONT];
  // Exhausted channel falls back to the node's own vector
  wire logic move_route = route_reg[best_idx] &&
    (win_cont || win_cnt != '0);
  wire logic move_fire = win_ok && move_route;
  wire logic last_move = move_fire && !win_cont &&
    win_cnt == CNT_W'(1);
  wire logic ack_take = cpu_ack & irq_valid_reg;
  wire logic [VEC_W-1:0] best_vec =
    VEC_W'({FIRST_TRAP + TRAP_W'(best_idx), 2'b00});

  // Nodes
  genvar gn;
  generate
    for (gn = 0; gn < NODES; gn++)
    begin : g_node
      wire logic node_wr = wr_acc && node_hit && node_idx == NODE_W'(gn);
      wire logic hw_set = node_hw_req[gn] |
        ((gn < SHARED) ? alt_src[gn % SHARED] : 1'b0);
      wire logic svc_clr =
        (ack_take && irq_node_reg == NODE_W'(gn)) ||
        (move_fire && !last_move && best_idx == NODE_W'(gn));
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          prio_reg[gn] <= '0;
          chsel_reg[gn] <= '0;
          en_reg[gn] <= 1'b0;
          route_reg[gn] <= 1'b0;
          req_reg[gn] <= 1'b0;
        end
        else
        begin
          if (node_wr)
          begin
            prio_reg[gn] <= pwdata[NC_PRIO_LSB +: PRIO_W];
            chsel_reg[gn] <= pwdata[NC_CH_LSB +: CH_W];
            en_reg[gn] <= pwdata[NC_EN_BIT];
            route_reg[gn] <= pwdata[NC_ROUTE_BIT];
          end
          // Hardware set wins over any clear
          if (hw_set)
            req_reg[gn] <= 1'b1;
          else if (node_wr)
            req_reg[gn] <= pwdata[NC_REQ_BIT];
          else if (svc_clr)
            req_reg[gn] <= 1'b0;
        end
      end
    end
  endgenerate

  // Transfer channels
  genvar gc;
  generate
    for (gc = 0; gc < CHANS; gc++)
    begin : g_chan
      wire logic ch_wr = wr_acc && chan_hit && ch_idx == CH_W'(gc);
      wire logic ch_mv = move_fire && win_ch == CH_W'(gc);
      wire logic [PTR_W-1:0] step =
        cfg_reg[gc][CFG_WORD] ? STEP_WORD : STEP_BYTE;
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          src_reg[gc] <= '0;
          dst_reg[gc] <= '0;
          cnt_reg[gc] <= '0;
          cfg_reg[gc] <= '0;
        end
        else if (ch_wr)
        begin
          if (ch_fld == CH_SRC)
            src_reg[gc] <= pwdata[PTR_W-1:0];
          if (ch_fld == CH_DST)
            dst_reg[gc] <= pwdata[PTR_W-1:0];
          if (ch_fld == CH_CNT)
            cnt_reg[gc] <= pwdata[CNT_W-1:0];
          if (ch_fld == CH_CFG)
            cfg_reg[gc] <= pwdata[CFG_W-1:0];
        end
        else if (ch_mv)
        begin
          if (cfg_reg[gc][CFG_INC_SRC])
            src_reg[gc] <= src_reg[gc] + step;
          if (cfg_reg[gc][CFG_INC_DST])
            dst_reg[gc] <= dst_reg[gc] + step;
          if (!cfg_reg[gc][CFG_CONT])
            cnt_reg[gc] <= cnt_reg[gc] - CNT_W'(1);
        end
      end
    end
  endgenerate

  // Nesting of accepted vectored services
  wire logic [LEVELS-1:0] top_bit = LEVELS'(1) << cur_level;
  wire logic [LEVELS-1:0] take_bit = LEVELS'(1) << irq_level_reg;

  always_comb
  begin
    isr_next = isr_reg;
    if (cpu_ret)
      isr_next = isr_next & ~top_bit;
    if (ack_take)
      isr_next = isr_next | take_bit;
  end

  // Channel exhaustion status, sticky; set beats write-one-clear
  wire logic [CHANS-1:0] stat_set = last_move ?
    (CHANS'(1) << win_ch) : '0;
  wire logic [CHANS-1:0] stat_clr = (wr_acc && stat_hit) ?
    pwdata[CHANS-1:0] : '0;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      edge_reg <= '0;
      mask_reg <= '0;
      stat_reg <= '0;
      isr_reg <= '0;
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
      ext_s3_reg <= '0;
    end
    else
    begin
      if (wr_acc && edge_hit)
        edge_reg <= pwdata[2*EXT_INS-1:0];
      if (wr_acc && mask_hit)
        mask_reg <= pwdata[CHANS-1:0];
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      isr_reg <= isr_next;
      ext_s1_reg <= fast_ext_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // CPU side: vector request, trap and one-cycle move
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_valid_reg <= 1'b0;
      irq_node_reg <= '0;
      irq_vector_reg <= '0;
      irq_level_reg <= '0;
      trap_valid_reg <= 1'b0;
      trap_vector_reg <= '0;
      move_valid_reg <= 1'b0;
      move_src_reg <= '0;
      move_dst_reg <= '0;
      move_word_reg <= 1'b0;
    end
    else
    begin
      // Offer dropped for one cycle after an acceptance
      irq_valid_reg <= win_ok && !move_route && !ack_take;
      irq_node_reg <= best_idx;
      irq_vector_reg <= best_vec;
      irq_level_reg <= best_prio;
      trap_valid_reg <= sw_trap;
      trap_vector_reg <= VEC_W'({sw_trap_num, 2'b00});
      move_valid_reg <= move_fire;
      move_src_reg <= src_reg[win_ch];
      move_dst_reg <= dst_reg[win_ch];
      move_word_reg <= win_cfg[CFG_WORD];
    end
  end

  // Register read
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    if (node_hit)
    begin
      rd_mux[NC_PRIO_LSB +: PRIO_W] = prio_reg[node_idx];
      rd_mux[NC_EN_BIT] = en_reg[node_idx];
      rd_mux[NC_REQ_BIT] = req_reg[node_idx];
      rd_mux[NC_ROUTE_BIT] = route_reg[node_idx];
      rd_mux[NC_CH_LSB +: CH_W] = chsel_reg[node_idx];
    end
    else if (chan_hit)
    begin
      if (ch_fld == CH_SRC)
        rd_mux[PTR_W-1:0] = src_reg[ch_idx];
      if (ch_fld == CH_DST)
        rd_mux[PTR_W-1:0] = dst_reg[ch_idx];
      if (ch_fld == CH_CNT)
        rd_mux[CNT_W-1:0] = cnt_reg[ch_idx];
      if (ch_fld == CH_CFG)
        rd_mux[CFG_W-1:0] = cfg_reg[ch_idx];
    end
    else if (edge_hit)
      rd_mux[2*EXT_INS-1:0] = edge_reg;
    else if (stat_hit)
      rd_mux[CHANS-1:0] = stat_reg;
    else if (mask_hit)
      rd_mux[CHANS-1:0] = mask_reg;
    else if (isr_hit)
      rd_mux[LEVELS-1:0] = isr_reg;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg <= pwrite ? '0 : rd_mux;
      pslverr_reg <= ~any_hit;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;
  assign irq_valid = irq_valid_reg;
  assign irq_vector = irq_vector_reg;
  assign irq_level = irq_level_reg;
  assign trap_valid = trap_valid_reg;
  assign trap_vector = trap_vector_reg;
  assign move_valid = move_valid_reg;
  assign move_src = move_src_reg;
  assign move_dst = move_dst_reg;
  assign move_word = move_word_reg;
  assign cpu_stall = move_valid_reg;
  assign irq_out = |(stat_reg & mask_reg);

endmodule

`default_nettype wire

/* File: tb/pie_ctrl_props.sv */
// Port assertions for the interrupt and transfer controller
`timescale 1ns/1ps
`default_nettype none
module pie_ctrl_props
  import pie_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic irq_valid,
  input wire logic [VEC_W-1:0] irq_vector,
  input wire logic [PRIO_W-1:0] irq_level,
  input wire logic cpu_ack,
  input wire logic cpu_ret,
  input wire logic sw_trap,
  input wire logic [TRAP_W-1:0] sw_trap_num,
  input wire logic trap_valid,
  input wire logic [VEC_W-1:0] trap_vector,
  input wire logic move_valid,
  input wire logic cpu_stall,
  input wire logic irq_out
);
  logic busy_reg;
  logic [PRIO_W-1:0] top_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Level of the latest accepted service until a return
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      busy_reg <= 1'b0;
      top_reg <= '0;
    end
    else if (irq_valid && cpu_ack)
    begin
      busy_reg <= 1'b1;
      top_reg <= irq_level;
    end
    else if (cpu_ret)
      busy_reg <= 1'b0;
  property p_trap_vec;
    sw_trap |=> trap_valid &&
      trap_vector == {6'h00, $past(sw_trap_num), 2'b00};
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector wrong");
  property p_trap_quiet;
    !sw_trap |=> !trap_valid;
  endproperty
  a_trap_quiet: assert property (p_trap_quiet)
    else $error("trap without request");
  property p_stall;
    cpu_stall == move_valid;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall differs from move");
  property p_vec_range;
    irq_valid |-> irq_vector[1:0] == 2'b00 &&
      irq_vector inside {[16'h0040:16'h007C]};
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("vector outside node table");
  property p_ack_drop;
    irq_valid && cpu_ack |=> !irq_valid;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("offer kept after accept");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err)
    else $error("error outside access phase");
  property p_irq_out;
    $rose(irq_out) |-> move_valid || $past(move_valid) ||
      $past(psel && penable && pwrite);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt line without cause");
  property p_preempt;
    irq_valid && busy_reg |-> irq_level > top_reg;
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("offer not above running level");
  c_move: cover property (move_valid);
  c_nest: cover property (irq_valid && busy_reg && cpu_ack);
  c_trap: cover property (trap_valid);
endmodule
bind pie_ctrl pie_ctrl_props i_pie_ctrl_props (
  .mclk, .reset_n, .psel, .penable, .pwrite, .pslverr, .irq_valid,
  .irq_vector, .irq_level, .cpu_ack, .cpu_ret, .sw_trap, .sw_trap_num,
  .trap_valid, .trap_vector, .move_valid, .cpu_stall, .irq_out
);
`default_nettype wire

/* File: tb/pie_cpu_model.sv */
// Core model that accepts offered vectored requests
`timescale 1ns/1ps
`default_nettype none
module pie_cpu_model #(parameter int ACK_WAIT = 2)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ack_en,
  input wire logic irq_valid,
  output logic cpu_ack
);
  logic [3:0] wait_reg;
  // Accepts a request still on offer, after a delay
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      wait_reg <= 4'h0;
      cpu_ack <= 1'b0;
    end
    else
    begin
      cpu_ack <= ack_en && irq_valid && !cpu_ack &&
        wait_reg == 4'(ACK_WAIT);
      wait_reg <= (ack_en && irq_valid && !cpu_ack) ?
        wait_reg + 4'h1 : 4'h0;
    end
endmodule
`default_nettype wire

/* File: tb/prioritized_interrupt_and_event_transfer_bench.sv */
// Self-checking bench for the interrupt and transfer controller
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_and_event_transfer_bench
  import pie_pkg::*;
;
  typedef struct packed
  {
    logic [11:0] a;
    logic [31:0] w, r;
    logic e;
  } pie_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_ret = 1'b0;
  logic sw_trap = 1'b0, ack_en = 1'b0, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [NODES-1:0] node_hw_req = '0;
  logic [SHARED-1:0] node_alt_req = '0;
  logic [EXT_INS-1:0] fast_ext_pin = '0;
  logic [TRAP_W-1:0] sw_trap_num = '0;
  logic pready, pslverr, irq_valid, cpu_ack, trap_valid, move_valid;
  logic move_word, cpu_stall, irq_out;
  logic [VEC_W-1:0] irq_vector, trap_vector;
  logic [PRIO_W-1:0] irq_level;
  logic [PTR_W-1:0] move_src, move_dst;
  int n_fail = 0, compares = 0, cycles = 0;
  pie_row_t rows [6] = '{
    '{12'h014, 32'hFFFF_FF7F, 32'h0000_0F4F, 1'b0},
    '{12'h170, 32'h1234_ABCD, 32'h0000_ABCD, 1'b0},
    '{12'h178, 32'h0000_01FF, 32'h0000_00FF, 1'b0},
    '{12'h17C, 32'hFFFF_FFFF, 32'h0000_000F, 1'b0},
    '{12'h20C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
    '{12'h300, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
  always #5 mclk = ~mclk;
  pie_ctrl i_pie_ctrl (
    .mclk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .node_hw_req, .node_alt_req, .fast_ext_pin,
    .irq_valid, .irq_vector, .irq_level, .cpu_ack, .cpu_ret, .sw_trap,
    .sw_trap_num, .trap_valid, .trap_vector, .move_valid, .move_src,
    .move_dst, .move_word, .cpu_stall, .irq_out
  );
  pie_cpu_model #(.ACK_WAIT(2)) i_pie_cpu_model (
    .mclk, .reset_n, .ack_en, .irq_valid, .cpu_ack
  );
  task automatic complete_run();
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_on(input logic w, input int lim);
    int k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    while ((w ? irq_valid : move_valid) !== 1'b1 && k < lim);
    chk(w ? irq_valid : move_valid, 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      chk(irq_valid, 1'b0);
    end
  endtask
  task automatic ret();
    @(posedge mclk);
    cpu_ret <= 1'b1;
    @(posedge mclk);
    cpu_ret <= 1'b0;
  endtask
  task automatic pulse(input int n, input logic alt);
    @(posedge mclk);
    if (alt)
      node_alt_req[n] <= 1'b1;
    else
      node_hw_req[n] <= 1'b1;
    @(posedge mclk);
    node_alt_req <= '0;
    node_hw_req <= '0;
  endtask
  task automatic move_chk(input int n, input logic [15:0] s, d,
    input logic w);
    pulse(n, 1'b0);
    wait_on(1'b0, 3);
    chk(move_src, s);
    chk(move_dst, d);
    chk(move_word, w);
    chk(cpu_stall, 1'b1);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    chk({pready, irq_valid, move_valid, irq_out}, 32'h8);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].r);
      chk(er, rows[i].e);
    end
    for (int i = 1; i < 4; i++)
    begin
      apb(1'b1, 12'h200, 32'(i));
      apb(1'b1, 12'h000, 32'h41);
      fast_ext_pin[0] <= 1'b1;
      repeat (6) @(posedge mclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[7], i[0]);
      apb(1'b1, 12'h000, 32'h41);
      fast_ext_pin[0] <= 1'b0;
      repeat (6) @(posedge mclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[7], i[1]);
    end
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h00C, 32'h45);
    apb(1'b1, 12'h024, 32'h47);
    apb(1'b1, 12'h008, 32'hC5);
    pulse(3, 1'b0);
    wait_on(1'b1, 8);
    chk(irq_vector, 16'h0048);
    chk(irq_level, 4'h5);
    ack_en <= 1'b1;
    repeat (6) @(posedge mclk);
    idle(4);
    pulse(9, 1'b1);
    wait_on(1'b1, 8);
    chk(irq_vector, 16'h0064);
    repeat (6) @(posedge mclk);
    ret();
    idle(4);
    ret();
    wait_on(1'b1, 8);
    chk(irq_vector, 16'h004C);
    repeat (6) @(posedge mclk);
    ret();
    apb(1'b1, 12'h110, 32'h1000);
    apb(1'b1, 12'h114, 32'h2000);
    apb(1'b1, 12'h118, 32'h2);
    apb(1'b1, 12'h11C, 32'h7);
    apb(1'b1, 12'h208, 32'h2);
    apb(1'b1, 12'h018, 32'h342);
    move_chk(6, 16'h1000, 16'h2000, 1'b1);
    move_chk(6, 16'h1002, 16'h2002, 1'b1);
    wait_on(1'b1, 4);
    chk(irq_vector, 16'h0058);
    chk(irq_out, 1'b1);
    apb(1'b0, 12'h118, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h208, 32'h0);
    #1;
    chk(irq_out, 1'b0);
    apb(1'b1, 12'h208, 32'h2);
    apb(1'b0, 12'h204, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 12'h204, 32'h2);
    #1;
    chk(irq_out, 1'b0);
    ret();
    apb(1'b1, 12'h120, 32'h3000);
    apb(1'b1, 12'h128, 32'h5);
    apb(1'b1, 12'h12C, 32'hA);
    apb(1'b1, 12'h01C, 32'h541);
    move_chk(7, 16'h3000, 16'h0000, 1'b0);
    move_chk(7, 16'h3001, 16'h0000, 1'b0);
    idle(3);
    apb(1'b0, 12'h128, 32'h0);
    chk(rd, 32'h5);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      sw_trap <= 1'b1;
      sw_trap_num <= i ? 8'hFF : 8'h10;
      @(posedge mclk);
      sw_trap <= 1'b0;
      #1;
      chk(trap_valid, 1'b1);
      chk(trap_vector, i ? 32'h03FC : 32'h0040);
    end
    complete_run();
  end
endmodule
`default_nettype wire
